// >>> hw/dtp_timer.sv
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
module dtp_timer (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output wire logic [15:0] reg_rdata,
   input  wire logic        slow_clk,
   input  wire logic        timer_io_pin_i,
   output wire logic        timer_io_pin_o,
   output wire logic        timer_io_pin_oe,
   output wire logic        irq_timer1,
   output wire logic        irq_timer2
);
   dtp_clk_if ck ();

   dtp_clk_src u_clk_src (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .slow_clk (slow_clk),
      .ck       (ck.src)
   );

   function automatic logic hit(input logic       stb,
                                input logic [3:0] a,
                                input logic [3:0] ofs);
      return stb && (a == ofs);
   endfunction

   logic [4:0]           presc_div_q;
   logic [4:0]           presc_div_d;
   dtp_pkg::dtp_clksel_t sel1_q;
   dtp_pkg::dtp_clksel_t sel1_d;
   dtp_pkg::dtp_clksel_t sel2_q;
   dtp_pkg::dtp_clksel_t sel2_d;
   dtp_pkg::dtp_mode_t   mode_q;
   dtp_pkg::dtp_mode_t   mode_d;
   logic                 act_en_q;
   logic                 act_en_d;
   logic                 rise_q;
   logic                 rise_d;
   logic                 init_q;
   logic                 init_d;
   logic [3:0]           ien_q;
   logic [3:0]           ien_d;
   logic [15:0]          cnt1_q;
   logic [15:0]          cnt1_d;
   logic [15:0]          cnt2_q;
   logic [15:0]          cnt2_d;
   logic [15:0]          rca_q;
   logic [15:0]          rca_d;
   logic [15:0]          rcb_q;
   logic [15:0]          rcb_d;
   logic                 next_b_q;
   logic                 next_b_d;
   logic [3:0]           pend_q;
   logic [3:0]           pend_d;
   logic                 pin_q;
   logic                 pin_d;
   logic                 pin_oe_q;
   logic                 pin_oe_d;
   logic                 pin_prev_q;
   logic                 irq1_q;
   logic                 irq1_d;
   logic                 irq2_q;
   logic                 irq2_d;
   logic [15:0]          rdata_q;
   logic [15:0]          rdata_d;

   logic                 tick1;
   logic                 tick2;
   logic                 uf1;
   logic                 uf2;
   logic                 pwm;
   logic                 toggling;
   logic                 cap_edge;
   logic [3:0]           set;
   logic [3:0]           clr;

   assign ck.divisor = presc_div_q;

   // event decode
   always_comb
   begin
      pwm      = (mode_q == dtp_pkg::DTP_MODE_PWM);
      // counters advance only on their own selected tick
      tick1    = dtp_pkg::dtp_sel_tick(sel1_q, ck.presc_tick,
                                       ck.slow_tick);
      tick2    = dtp_pkg::dtp_sel_tick(sel2_q, ck.presc_tick,
                                       ck.slow_tick);
      uf1      = tick1 && (cnt1_q == dtp_pkg::DTP_WORD_RST);
      uf2      = tick2 && (cnt2_q == dtp_pkg::DTP_WORD_RST);
      toggling = pwm && act_en_q && (sel1_q != dtp_pkg::DTP_SEL_NONE);
      // edge polarity chosen by software
      cap_edge = !pwm && (rise_q ? (timer_io_pin_i && !pin_prev_q)
                                 : (!timer_io_pin_i && pin_prev_q));
      set      = 4'h0;
      set[dtp_pkg::DTP_IRQ_A] = pwm ? (uf1 && !next_b_q)
                                    : cap_edge;
      set[dtp_pkg::DTP_IRQ_B] = pwm && uf1 && next_b_q;
      set[dtp_pkg::DTP_IRQ_C] = !pwm && uf1;
      set[dtp_pkg::DTP_IRQ_D] = uf2;
      clr = hit(reg_wr, reg_addr, dtp_pkg::DTP_OFS_ICLR) ?
            reg_wdata[3:0] : 4'h0;
   end

   // control registers written by software
   always_comb
   begin
      presc_div_d = presc_div_q;
      sel1_d      = sel1_q;
      sel2_d      = sel2_q;
      mode_d      = mode_q;
      act_en_d    = act_en_q;
      rise_d      = rise_q;
      init_d      = init_q;
      ien_d       = ien_q;
      if (hit(reg_wr, reg_addr, dtp_pkg::DTP_OFS_PRESC))
         presc_div_d = reg_wdata[4:0];
      if (hit(reg_wr, reg_addr, dtp_pkg::DTP_OFS_CLKSEL))
      begin
         sel1_d = dtp_pkg::dtp_clksel_t'(
                     reg_wdata[dtp_pkg::DTP_SEL1_LSB +: 2]);
         sel2_d = dtp_pkg::dtp_clksel_t'(
                     reg_wdata[dtp_pkg::DTP_SEL2_LSB +: 2]);
      end
      if (hit(reg_wr, reg_addr, dtp_pkg::DTP_OFS_MODE))
      begin
         mode_d   = dtp_pkg::dtp_mode_t'(reg_wdata[dtp_pkg::DTP_MODE_CAP]);
         act_en_d = reg_wdata[dtp_pkg::DTP_MODE_ACT];
         rise_d   = reg_wdata[dtp_pkg::DTP_MODE_RISE];
         init_d   = reg_wdata[dtp_pkg::DTP_MODE_INIT];
      end
      if (hit(reg_wr, reg_addr, dtp_pkg::DTP_OFS_IEN))
         ien_d = reg_wdata[3:0];
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         presc_div_q <= dtp_pkg::DTP_PRESC_RST;
         sel1_q      <= dtp_pkg::DTP_SEL_NONE;
         sel2_q      <= dtp_pkg::DTP_SEL_NONE;
         mode_q      <= dtp_pkg::DTP_MODE_PWM;
         act_en_q    <= 1'b0;
         rise_q      <= 1'b0;
         init_q      <= 1'b0;
         ien_q       <= dtp_pkg::DTP_FLAG_RST;
      end
      else
      begin
         presc_div_q <= presc_div_d;
         sel1_q      <= sel1_d;
         sel2_q      <= sel2_d;
         mode_q      <= mode_d;
         act_en_q    <= act_en_d;
         rise_q      <= rise_d;
         init_q      <= init_d;
         ien_q       <= ien_d;
      end
   end

   // counters and reload or capture registers; state holds between
   // ticks, so a stopped mclk simply freezes it
   always_comb
   begin
      cnt1_d   = cnt1_q;
      cnt2_d   = cnt2_q;
      rca_d    = rca_q;
      rcb_d    = rcb_q;
      next_b_d = next_b_q;
      if (hit(reg_wr, reg_addr, dtp_pkg::DTP_OFS_CNT1))
         cnt1_d = reg_wdata;
      if (hit(reg_wr, reg_addr, dtp_pkg::DTP_OFS_CNT2))
         cnt2_d = reg_wdata;
      if (hit(reg_wr, reg_addr, dtp_pkg::DTP_OFS_RCA))
         rca_d = reg_wdata;
      if (hit(reg_wr, reg_addr, dtp_pkg::DTP_OFS_RCB))
         rcb_d = reg_wdata;
      if (tick1)
         cnt1_d = cnt1_q - 16'h0001;
      if (pwm && uf1)
      begin
         cnt1_d   = next_b_q ? rcb_q : rca_q;
         next_b_d = !next_b_q;
      end
      if (!pwm || sel1_q == dtp_pkg::DTP_SEL_NONE)
         next_b_d = 1'b0;
      if (cap_edge)
      begin
         rca_d = cnt1_q;
         if (act_en_q)
            cnt1_d = dtp_pkg::DTP_PRESET;
      end
      if (tick2)
         cnt2_d = cnt2_q - 16'h0001;
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         cnt1_q   <= dtp_pkg::DTP_WORD_RST;
         cnt2_q   <= dtp_pkg::DTP_WORD_RST;
         rca_q    <= dtp_pkg::DTP_WORD_RST;
         rcb_q    <= dtp_pkg::DTP_WORD_RST;
         next_b_q <= 1'b0;
      end
      else
      begin
         cnt1_q   <= cnt1_d;
         cnt2_q   <= cnt2_d;
         rca_q    <= rca_d;
         rcb_q    <= rcb_d;
         next_b_q <= next_b_d;
      end
   end

   // pending flags, interrupt lines and pin
   always_comb
   begin
      pend_d   = (pend_q & ~clr) | set;
      irq1_d   = |(pend_d[2:0] & ien_d[2:0]);
      irq2_d   = pend_d[dtp_pkg::DTP_IRQ_D] &
                 ien_d[dtp_pkg::DTP_IRQ_D];
      pin_oe_d = pwm && act_en_q;
      pin_d    = pin_q;
      if (!toggling)
         pin_d = init_q;
      else if (uf1)
         pin_d = !pin_q;
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         pend_q     <= dtp_pkg::DTP_FLAG_RST;
         irq1_q     <= 1'b0;
         irq2_q     <= 1'b0;
         pin_q      <= 1'b0;
         pin_oe_q   <= 1'b0;
         pin_prev_q <= 1'b0;
      end
      else
      begin
         pend_q     <= pend_d;
         irq1_q     <= irq1_d;
         irq2_q     <= irq2_d;
         pin_q      <= pin_d;
         pin_oe_q   <= pin_oe_d;
         pin_prev_q <= timer_io_pin_i;
      end
   end

   // read port, data one cycle after the strobe
   always_comb
   begin
      rdata_d = 16'h0000;
      if (reg_rd)
      begin
         unique case (reg_addr)
            dtp_pkg::DTP_OFS_PRESC:  rdata_d = {11'h000, presc_div_q};
            dtp_pkg::DTP_OFS_CLKSEL: rdata_d = {12'h000, sel2_q, sel1_q};
            dtp_pkg::DTP_OFS_CNT1:   rdata_d = cnt1_q;
            dtp_pkg::DTP_OFS_CNT2:   rdata_d = cnt2_q;
            dtp_pkg::DTP_OFS_RCA:    rdata_d = rca_q;
            dtp_pkg::DTP_OFS_RCB:    rdata_d = rcb_q;
            dtp_pkg::DTP_OFS_MODE:
               rdata_d = {12'h000, init_q, rise_q, act_en_q, mode_q};
            dtp_pkg::DTP_OFS_IEN:    rdata_d = {12'h000, ien_q};
            dtp_pkg::DTP_OFS_PEND:   rdata_d = {12'h000, pend_q};
            default:                 rdata_d = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         rdata_q <= 16'h0000;
      else
         rdata_q <= rdata_d;
   end

   assign reg_rdata       = rdata_q;
   assign timer_io_pin_o  = pin_q;
   assign timer_io_pin_oe = pin_oe_q;
   assign irq_timer1      = irq1_q;
   assign irq_timer2      = irq2_q;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   sequence s_reload_a;
      pwm && uf1 && !next_b_q && !cap_edge;
   endsequence
   sequence s_loaded_a;
      next_b_q && cnt1_q == $past(rca_q);
   endsequence

   property p_reload_alt;
      s_reload_a |=> s_loaded_a;
   endproperty
   a_reload_alt: assert property (p_reload_alt)
      else $error("pwm reload from first register wrong");

   property p_restart_a;
      sel1_q == dtp_pkg::DTP_SEL_NONE |=> !next_b_q;
   endproperty
   a_restart_a: assert property (p_restart_a)
      else $error("alternation not reset on stop");

   property p_toggle;
      toggling && uf1 && $stable(mode_q) |=> pin_q != $past(pin_q);
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("pin did not toggle on underflow");

   property p_capture;
      cap_edge |=> rca_q == $past(cnt1_q);
   endproperty
   a_capture: assert property (p_capture)
      else $error("capture did not store count");

   property p_preset;
      cap_edge && act_en_q |=> cnt1_q == 16'hffff;
   endproperty
   a_preset: assert property (p_preset)
      else $error("counter not preset after capture");

   property p_set_wins;
      set[dtp_pkg::DTP_IRQ_D] |=> pend_q[dtp_pkg::DTP_IRQ_D] ##1 1'b1;
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("pending flag lost");

   property p_irq2;
      uf2 && ien_q[dtp_pkg::DTP_IRQ_D] &&
      !hit(reg_wr, reg_addr, dtp_pkg::DTP_OFS_IEN) |=> irq_timer2;
   endproperty
   a_irq2: assert property (p_irq2)
      else $error("second interrupt not raised");

   property p_halt;
      sel2_q == dtp_pkg::DTP_SEL_NONE &&
      !hit(reg_wr, reg_addr, dtp_pkg::DTP_OFS_CNT2)
         |=> cnt2_q == $past(cnt2_q);
   endproperty
   a_halt: assert property (p_halt)
      else $error("counter two moved without clock");

   property p_off_after_rst;
      disable iff (1'b0)
      !rst_n |=> sel1_q == dtp_pkg::DTP_SEL_NONE &&
                 sel2_q == dtp_pkg::DTP_SEL_NONE;
   endproperty
   a_off_after_rst: assert property (p_off_after_rst)
      else $error("counters enabled after reset");
endmodule // dtp_timer

// >>> inc/dtp_pkg.sv
package dtp_pkg;
   localparam int         DTP_AW = 4;
   localparam int         DTP_DW = 16;
   localparam int         DTP_PW = 5;
   // register offsets on the plain register port
   localparam logic [3:0] DTP_OFS_PRESC  = 4'h0;
   localparam logic [3:0] DTP_OFS_CLKSEL = 4'h1;
   localparam logic [3:0] DTP_OFS_CNT1   = 4'h2;
   localparam logic [3:0] DTP_OFS_CNT2   = 4'h3;
   localparam logic [3:0] DTP_OFS_RCA    = 4'h4;
   localparam logic [3:0] DTP_OFS_RCB    = 4'h5;
   localparam logic [3:0] DTP_OFS_MODE   = 4'h6;
   localparam logic [3:0] DTP_OFS_IEN    = 4'h7;
   localparam logic [3:0] DTP_OFS_PEND   = 4'h8;
   localparam logic [3:0] DTP_OFS_ICLR   = 4'h9;
   // field positions
   localparam int         DTP_SEL1_LSB   = 0;
   localparam int         DTP_SEL2_LSB   = 2;
   localparam int         DTP_MODE_CAP   = 0;
   localparam int         DTP_MODE_ACT   = 1;
   localparam int         DTP_MODE_RISE  = 2;
   localparam int         DTP_MODE_INIT  = 3;
   localparam int         DTP_IRQ_A      = 0;
   localparam int         DTP_IRQ_B      = 1;
   localparam int         DTP_IRQ_C      = 2;
   localparam int         DTP_IRQ_D      = 3;
   // reset and preset values
   localparam logic [4:0]  DTP_PRESC_RST = 5'h00;
   localparam logic [15:0] DTP_WORD_RST  = 16'h0000;
   localparam logic [15:0] DTP_PRESET    = 16'hffff;
   localparam logic [3:0]  DTP_FLAG_RST  = 4'h0;
   // slow clock may run at most one quarter of mclk
   localparam int          DTP_SLOW_DIV  = 4;

   typedef enum logic [1:0] {
      DTP_SEL_NONE  = 2'b00,
      DTP_SEL_PRESC = 2'b01,
      DTP_SEL_SLOW  = 2'b10
   } dtp_clksel_t;

   typedef enum logic {
      DTP_MODE_PWM  = 1'b0,
      DTP_MODE_CAPT = 1'b1
   } dtp_mode_t;

   function automatic logic dtp_sel_tick(input logic [1:0] sel,
                                         input logic       presc,
                                         input logic       slow);
      logic t;
      t = 1'b0;
      if (sel == DTP_SEL_PRESC)
         t = presc;
      else if (sel == DTP_SEL_SLOW)
         t = slow;
      return t;
   endfunction
endpackage

// >>> inc/dtp_clk_if.sv
`timescale 1ns/1ps
interface dtp_clk_if;
   logic [4:0] divisor;
   logic       presc_tick;
   logic       slow_tick;
   modport src (input divisor, output presc_tick, output slow_tick);
   modport snk (output divisor, input presc_tick, input slow_tick);
endinterface

// >>> hw/dtp_clk_src.sv
`timescale 1ns/1ps
module dtp_clk_src (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic slow_clk,
   dtp_clk_if.src    ck
);
   logic [4:0] pcnt_q;
   logic [4:0] pcnt_d;
   logic       ptick_q;
   logic       ptick_d;
   logic       s1_q;
   logic       s2_q;
   logic       s3_q;
   logic       stick_q;
   logic       stick_d;

   always_comb
   begin
      // divide by divisor plus one
      ptick_d = (pcnt_q == 5'h00);
      pcnt_d  = ptick_d ? ck.divisor : pcnt_q - 5'h01;
      // one pulse per slow rising edge
      stick_d = s2_q & ~s3_q;
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         pcnt_q  <= dtp_pkg::DTP_PRESC_RST;
         ptick_q <= 1'b0;
         s1_q    <= 1'b0;
         s2_q    <= 1'b0;
         s3_q    <= 1'b0;
         stick_q <= 1'b0;
      end
      else
      begin
         pcnt_q  <= pcnt_d;
         ptick_q <= ptick_d;
         s1_q    <= slow_clk;
         s2_q    <= s1_q;
         s3_q    <= s2_q;
         stick_q <= stick_d;
      end
   end

   assign ck.presc_tick = ptick_q;
   assign ck.slow_tick  = stick_q;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   property p_presc_reload;
      ptick_q |-> pcnt_q == $past(ck.divisor);
   endproperty
   a_presc_reload: assert property (p_presc_reload)
      else $error("prescaler not reloaded from divisor");

   property p_slow_pulse;
      stick_q |=> !stick_q;
   endproperty
   a_slow_pulse: assert property (p_slow_pulse)
      else $error("slow tick wider than one cycle");

   property p_slow_edge;
      $rose(s2_q) |=> stick_q;
   endproperty
   a_slow_edge: assert property (p_slow_edge)
      else $error("slow edge not turned into a tick");

   property p_presc_rst;
      disable iff (1'b0) !rst_n |=> pcnt_q == 5'h00 && !ptick_q;
   endproperty
   a_presc_rst: assert property (p_presc_rst)
      else $error("prescaler not cleared by reset");
endmodule // dtp_clk_src

// >>> verif/dtp_pin_agent.sv
`timescale 1ns/1ps
module dtp_pin_agent (
   input  wire logic mclk,
   input  wire logic lvl_req,
   input  wire logic pin_o,
   input  wire logic pin_oe,
   output wire logic pin_i,
   output logic      slow_clk
);
   logic src_q = 1'b0;

   // source level moves only on mclk, so each level lasts a cycle
   always_ff @(posedge mclk)
   begin
      src_q <= lvl_req;
   end

   // wire level: the timer wins while its drive enable is high
   assign pin_i = pin_oe ? pin_o : src_q;

   // free slow clock at mclk/8, phase unrelated to mclk
   // mclk itself never runs from this clock here
   initial
   begin
      slow_clk = 1'b0;
      #7;
      forever #100 slow_clk = ~slow_clk;
   end
endmodule // dtp_pin_agent

// >>> verif/dtp_timer_tb.sv
`timescale 1ns/1ps
module dtp_timer_tb;
   logic        mclk;
   logic        rst_n;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_rdata;
   logic        slow_clk;
   logic        pin_i;
   logic        pin_o;
   logic        pin_oe;
   logic        irq1;
   logic        irq2;
   logic        lvl;
   logic [15:0] v;
   logic [15:0] w;
   int          n_errors;
   int          checks;
   int          cyc;
   int          h;
   int          i;
   int          dv[3] = '{0, 4, 31};

   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   dtp_timer u_dut (
      .mclk            (mclk),
      .rst_n           (rst_n),
      .reg_addr        (reg_addr),
      .reg_wdata       (reg_wdata),
      .reg_wr          (reg_wr),
      .reg_rd          (reg_rd),
      .reg_rdata       (reg_rdata),
      .slow_clk        (slow_clk),
      .timer_io_pin_i  (pin_i),
      .timer_io_pin_o  (pin_o),
      .timer_io_pin_oe (pin_oe),
      .irq_timer1      (irq1),
      .irq_timer2      (irq2)
   );

   dtp_pin_agent u_pin (
      .mclk     (mclk),
      .lvl_req  (lvl),
      .pin_o    (pin_o),
      .pin_oe   (pin_oe),
      .pin_i    (pin_i),
      .slow_clk (slow_clk)
   );

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rchk(input string nm, input logic [3:0] a,
                       input logic [15:0] e);
      logic [15:0] d;
      rd(a, d);
      chk(nm, e, d);
   endtask

   task automatic waitc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // count cycles for which the pin stays at lv, sampled after each edge
   task automatic len(input logic lv, output int n);
      n = 0;
      while (pin_o === lv && n < 200)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
   endtask

   task automatic wait_lv(input logic lv);
      int k;
      k = 0;
      while (pin_o !== lv && k < 200)
      begin
         @(posedge mclk);
         #1;
         k++;
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 10000)
      begin
         n_errors++;
         wrap_up;
      end
   end

   initial
   begin
      rst_n     = 1'b0;
      reg_addr  = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      lvl       = 1'b0;
      n_errors  = 0;
      checks    = 0;
      cyc       = 0;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      // reset state, unmapped place
      rchk("presc", dtp_pkg::DTP_OFS_PRESC, 16'h0000);
      rchk("clksel", dtp_pkg::DTP_OFS_CLKSEL, 16'h0000);
      wr(4'ha, 16'h001f);
      rchk("unmapped", 4'ha, 16'h0000);
      rchk("presc", dtp_pkg::DTP_OFS_PRESC, 16'h0000);
      waitc(40);
      rchk("cnt1", dtp_pkg::DTP_OFS_CNT1, 16'h0000);
      rchk("cnt2", dtp_pkg::DTP_OFS_CNT2, 16'h0000);
      chk("oe", 16'h0000, 16'(pin_oe));
      $display("test reset done");
      // prescaled rate on counter one
      foreach (dv[j])
      begin
         wr(dtp_pkg::DTP_OFS_PRESC, 16'(dv[j]));
         rchk("presc", dtp_pkg::DTP_OFS_PRESC, 16'(dv[j]));
         // load before the clock runs on the first pass: a tick beats a software write
         wr(dtp_pkg::DTP_OFS_CNT1, 16'h1000);
         wr(dtp_pkg::DTP_OFS_CLKSEL, 16'h0001);
         rd(dtp_pkg::DTP_OFS_CNT1, v);
         waitc(4 * (dv[j] + 1) - 2);
         rd(dtp_pkg::DTP_OFS_CNT1, w);
         chk("rate", 16'h0004, v - w);
      end
      wr(dtp_pkg::DTP_OFS_CLKSEL, 16'h0000);
      rd(dtp_pkg::DTP_OFS_CNT1, v);
      waitc(20);
      rchk("halt", dtp_pkg::DTP_OFS_CNT1, v);
      $display("test prescaler done");
      // slow clock on counter two
      wr(dtp_pkg::DTP_OFS_CNT2, 16'h0064);
      wr(dtp_pkg::DTP_OFS_CLKSEL, 16'h0008);
      rd(dtp_pkg::DTP_OFS_CNT2, v);
      waitc(78);
      rd(dtp_pkg::DTP_OFS_CNT2, w);
      chk("slow rate", 16'h000a, v - w);
      wr(dtp_pkg::DTP_OFS_IEN, 16'h0008);
      wr(dtp_pkg::DTP_OFS_CNT2, 16'h0000);
      for (i = 0; i < 60 && irq2 !== 1'b1; i++)
         @(posedge mclk);
      chk("irq2", 16'h0001, 16'(irq2));
      rchk("pend", dtp_pkg::DTP_OFS_PEND, 16'h0008);
      wr(dtp_pkg::DTP_OFS_IEN, 16'h0000);
      waitc(2);
      chk("irq2 mask", 16'h0000, 16'(irq2));
      wr(dtp_pkg::DTP_OFS_CLKSEL, 16'h0000);
      wr(dtp_pkg::DTP_OFS_ICLR, 16'h000f);
      rchk("pend", dtp_pkg::DTP_OFS_PEND, 16'h0000);
      $display("test slow done");
      // pwm: with init low, high from first register, low from second
      wr(dtp_pkg::DTP_OFS_PRESC, 16'h0000);
      wr(dtp_pkg::DTP_OFS_RCA, 16'h0003);
      wr(dtp_pkg::DTP_OFS_RCB, 16'h0005);
      wr(dtp_pkg::DTP_OFS_CNT1, 16'h0000);
      wr(dtp_pkg::DTP_OFS_IEN, 16'h0003);
      wr(dtp_pkg::DTP_OFS_MODE, 16'h0002);
      wr(dtp_pkg::DTP_OFS_CLKSEL, 16'h0001);
      wait_lv(1'b1);
      len(1'b1, h);
      chk("high", 16'h0004, 16'(h));
      len(1'b0, h);
      chk("low", 16'h0006, 16'(h));
      chk("oe", 16'h0001, 16'(pin_oe));
      wr(dtp_pkg::DTP_OFS_CLKSEL, 16'h0000);
      rchk("pend", dtp_pkg::DTP_OFS_PEND, 16'h0003);
      chk("irq1", 16'h0001, 16'(irq1));
      wr(dtp_pkg::DTP_OFS_ICLR, 16'h0003);
      rchk("pend", dtp_pkg::DTP_OFS_PEND, 16'h0000);
      chk("irq1", 16'h0000, 16'(irq1));
      wr(dtp_pkg::DTP_OFS_MODE, 16'h000a);
      waitc(3);
      chk("init", 16'h0001, 16'(pin_o));
      wr(dtp_pkg::DTP_OFS_CLKSEL, 16'h0001);
      wait_lv(1'b0);
      len(1'b0, h);
      chk("restart", 16'h0004, 16'(h));
      $display("test pwm done");
      // capture with preset, rising then falling
      wr(dtp_pkg::DTP_OFS_CLKSEL, 16'h0000);
      wr(dtp_pkg::DTP_OFS_ICLR, 16'h000f);
      wr(dtp_pkg::DTP_OFS_CNT1, 16'h01f4);
      wr(dtp_pkg::DTP_OFS_MODE, 16'h0007);
      waitc(3);
      lvl <= 1'b1;
      waitc(4);
      rchk("rca", dtp_pkg::DTP_OFS_RCA, 16'h01f4);
      rchk("cnt1", dtp_pkg::DTP_OFS_CNT1, 16'hffff);
      rchk("pend", dtp_pkg::DTP_OFS_PEND, 16'h0001);
      wr(dtp_pkg::DTP_OFS_ICLR, 16'h0001);
      wr(dtp_pkg::DTP_OFS_CNT1, 16'h0007);
      lvl <= 1'b0;
      waitc(4);
      rchk("rca", dtp_pkg::DTP_OFS_RCA, 16'h01f4);
      rchk("pend", dtp_pkg::DTP_OFS_PEND, 16'h0000);
      wr(dtp_pkg::DTP_OFS_MODE, 16'h0003);
      wr(dtp_pkg::DTP_OFS_CNT1, 16'h0009);
      lvl <= 1'b1;
      waitc(3);
      lvl <= 1'b0;
      waitc(4);
      rchk("rca", dtp_pkg::DTP_OFS_RCA, 16'h0009);
      rchk("cnt1", dtp_pkg::DTP_OFS_CNT1, 16'hffff);
      wr(dtp_pkg::DTP_OFS_ICLR, 16'h000f);
      wr(dtp_pkg::DTP_OFS_IEN, 16'h0004);
      wr(dtp_pkg::DTP_OFS_MODE, 16'h0001);
      wr(dtp_pkg::DTP_OFS_CNT1, 16'h0002);
      wr(dtp_pkg::DTP_OFS_CLKSEL, 16'h0001);
      waitc(8);
      wr(dtp_pkg::DTP_OFS_CLKSEL, 16'h0000);
      rchk("pend", dtp_pkg::DTP_OFS_PEND, 16'h0004);
      chk("irq1", 16'h0001, 16'(irq1));
      $display("test capture done");
      wrap_up;
   end
endmodule // dtp_timer_tb
